// ---- test_transfer_request_submission.sv ----
`timescale 1ns/100ps
module test_transfer_request_submission;
   import trs_pkg::*;
   typedef struct packed {
      logic [CNT_W-1:0] count;
      trs_queue_type queue;
   } trs_exp_type;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   trs_cpu_type cpu_i = '0;
   logic l2_size_zero_i = 1'b1;
   trs_quick_type quick_i = '0;
   trs_event_type event_i = '0;
   trs_host_type host_i = '0;
   logic [3:0] host_rd_level_i = 4'h0;
   logic slow = 1'b0;
   logic tc_accept_i, cpu_ready_o, quick_ready_o, event_ready_o;
   logic host_ready_o, cfg_bus_req_o, sram_req_o, tr_valid_o;
   trs_request_type tr_o;
   logic [4:0] urgent_level_o, high_level_o, low_level_o;
   trs_exp_type exp_q[$];
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int seed = 56;
   // ==========================================
   // clock, design and partner
   always #2.5 clk_i = ~clk_i;
   trs_submit dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_i(cpu_i),
      .l2_size_zero_i(l2_size_zero_i), .quick_i(quick_i), .event_i(event_i),
      .host_i(host_i), .host_rd_level_i(host_rd_level_i),
      .tc_accept_i(tc_accept_i), .cpu_ready_o(cpu_ready_o),
      .quick_ready_o(quick_ready_o), .event_ready_o(event_ready_o),
      .host_ready_o(host_ready_o), .cfg_bus_req_o(cfg_bus_req_o),
      .sram_req_o(sram_req_o), .tr_valid_o(tr_valid_o), .tr_o(tr_o),
      .urgent_level_o(urgent_level_o), .high_level_o(high_level_o),
      .low_level_o(low_level_o));
   trs_tc_model tc_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
      .valid_i(tr_valid_o), .accept_o(tc_accept_i));
   // ==========================================
   // checking
   task check(input logic [CNT_W+1:0] seen, input logic [CNT_W+1:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h", $time, seen, want);
      end
   endtask : check
   task finish_test;
      if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   // compare each accepted request with the oldest note
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 20000) begin
         bad_count++;
         finish_test();
      end else if (!sys_rst_i && tr_valid_o === 1'b1 &&
            tc_accept_i === 1'b1) begin
         if (exp_q.size() == 0)
            check({tr_o.count, tr_o.queue}, 18'h3FFFF);
         else
            check({tr_o.count, tr_o.queue}, exp_q.pop_front());
      end
   end
   // ==========================================
   // stimulus tasks, all entered at a falling edge
   task cpu(input trs_region_type rg, input logic wr, l1h, l2h, vd);
      while (cpu_ready_o !== 1'b1) @(negedge clk_i);
      cpu_i = {1'b1, wr, rg, l1h, l2h, vd, 32'($random(seed)), 32'h0000_1000};
      @(negedge clk_i);
      cpu_i.valid = 1'b0;
      @(negedge clk_i);
   endtask : cpu
   task quick(input trs_queue_type q);
      logic [CNT_W-1:0] n;
      n = 16'($random(seed)) & 16'h00FF;
      exp_q.push_back({n, (q == TRS_Q_URGENT) ? TRS_Q_HIGH : q});
      while (quick_ready_o !== 1'b1) @(negedge clk_i);
      quick_i = {1'b1, 32'($random(seed)), 32'h0000_2000, n, TRS_AM_INC,
         TRS_AM_INDEX, q};
      @(negedge clk_i);
      quick_i.valid = 1'b0;
      @(negedge clk_i);
   endtask : quick
   task chan(input logic s2d, d2d, fs, input trs_queue_type q);
      logic [CNT_W-1:0] el;
      logic [CNT_W-1:0] ar;
      logic [CNT_W-1:0] n;
      el = (16'($random(seed)) & 16'h003F) + 16'h0001;
      ar = 16'($random(seed)) & 16'h0007;
      if (!s2d && !d2d) n = fs ? el : ONE_ELEMENT;
      else n = fs ? (ar + 16'h0001) * el : el;
      exp_q.push_back({n, q});
      while (event_ready_o !== 1'b1) @(negedge clk_i);
      event_i = {1'b1, s2d, d2d, fs, el, ar, 32'h0000_3000, 32'h0000_4000,
         16'h0000, TRS_AM_FIXED, TRS_AM_DEC, q};
      @(negedge clk_i);
      event_i.valid = 1'b0;
      @(negedge clk_i);
   endtask : chan
   task host(input logic wr, ai, input logic [3:0] lvl,
      input logic [CNT_W-1:0] n);
      if (n != 16'h0000) exp_q.push_back({n, TRS_Q_HIGH});
      while (host_ready_o !== 1'b1) @(negedge clk_i);
      // level changes only once the previous access is decided
      host_rd_level_i = lvl;
      host_i = {1'b1, wr, ai, 32'($random(seed)), 32'h0000_5000};
      @(negedge clk_i);
      host_i.valid = 1'b0;
      @(negedge clk_i);
   endtask : host
   task drain;
      for (int i = 0; i < 300 && (exp_q.size() != 0 ||
            tr_valid_o !== 1'b0); i++)
         @(negedge clk_i);
      repeat (4) @(negedge clk_i);
   endtask : drain
   // ==========================================
   // main sequence
   initial begin
      repeat (4) @(negedge clk_i);
      sys_rst_i = 1'b0;
      exp_q.push_back({ONE_ELEMENT, TRS_Q_URGENT});
      cpu(TRS_RG_EXT_NC, 1'b0, 1'b0, 1'b0, 1'b0);
      exp_q.push_back({ONE_ELEMENT, TRS_Q_URGENT});
      cpu(TRS_RG_EXT_C, 1'b1, 1'b0, 1'b0, 1'b0);
      exp_q.push_back({L1_LINE_BYTES, TRS_Q_URGENT});
      cpu(TRS_RG_EXT_C, 1'b0, 1'b0, 1'b0, 1'b0);
      cpu(TRS_RG_EXT_C, 1'b0, 1'b1, 1'b0, 1'b0);
      cpu(TRS_RG_CTRL_REG, 1'b0, 1'b0, 1'b0, 1'b0);
      cpu(TRS_RG_L2_SRAM, 1'b0, 1'b0, 1'b0, 1'b0);
      cpu(TRS_RG_INTERNAL, 1'b1, 1'b0, 1'b0, 1'b0);
      drain();
      l2_size_zero_i = 1'b0;
      slow = 1'b1;
      exp_q.push_back({L2_HALF_BYTES, TRS_Q_URGENT});
      exp_q.push_back({L2_HALF_BYTES, TRS_Q_URGENT});
      cpu(TRS_RG_EXT_C, 1'b0, 1'b0, 1'b0, 1'b0);
      cpu(TRS_RG_EXT_C, 1'b0, 1'b0, 1'b1, 1'b0);
      exp_q.push_back({L2_LINE_BYTES, TRS_Q_URGENT});
      exp_q.push_back({L2_HALF_BYTES, TRS_Q_URGENT});
      exp_q.push_back({L2_HALF_BYTES, TRS_Q_URGENT});
      cpu(TRS_RG_EXT_C, 1'b0, 1'b0, 1'b0, 1'b1);
      exp_q.push_back({ONE_ELEMENT, TRS_Q_URGENT});
      cpu(TRS_RG_EXT_NC, 1'b1, 1'b0, 1'b0, 1'b0);
      drain();
      slow = 1'b0;
      quick(TRS_Q_URGENT);
      quick(TRS_Q_HIGH);
      quick(TRS_Q_LOW);
      for (int i = 0; i < 8; i++) begin
         chan(i[0], i[1], i[2], i[0] ? TRS_Q_LOW : TRS_Q_HIGH);
      end
      drain();
      host(1'b0, 1'b0, 4'h6, ONE_ELEMENT);
      host(1'b1, 1'b0, 4'h0, ONE_ELEMENT);
      host(1'b0, 1'b1, 4'h0, HOST_BURST_FULL);
      host(1'b0, 1'b1, 4'h4, HOST_BURST_HALF);
      host(1'b0, 1'b1, 4'h5, 16'h0000);
      host(1'b0, 1'b1, 4'h1, HOST_BURST_HALF);
      drain();
      for (int i = 0; i < 8; i++) begin
         host(1'b1, 1'b1, 4'h0, (i % 4 == 3) ? HOST_BURST_HALF : 16'h0000);
      end
      drain();
      // nine urgent, thirteen high and five low requests were sent
      check({13'h0000, urgent_level_o}, 18'(URGENT_DEPTH));
      check({13'h0000, high_level_o}, 18'(HIGH_DEPTH));
      check({13'h0000, low_level_o}, 18'h00005);
      finish_test();
   end
endmodule : test_transfer_request_submission

// ---- trs_pkg.sv ----
package trs_pkg;

   // ==========================================================
   // widths and sizes
   localparam int ADDR_W = 32;
   localparam int CNT_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam logic [CNT_W-1:0] ONE_ELEMENT = 16'h0001;
   localparam logic [CNT_W-1:0] L1_LINE_BYTES = 16'h0020;
   localparam logic [CNT_W-1:0] L2_LINE_BYTES = 16'h0080;
   localparam logic [CNT_W-1:0] L2_HALF_BYTES = 16'h0040;
   localparam logic [CNT_W-1:0] HOST_BURST_FULL = 16'h0008;
   localparam logic [CNT_W-1:0] HOST_BURST_HALF = 16'h0004;
   localparam logic [3:0] HOST_FIFO_HALF = 4'h4;
   localparam logic [2:0] HOST_WR_GROUP = 3'h4;

   // ==========================================================
   // queue depths of the transfer controller
   localparam int URGENT_DEPTH = 6;
   localparam int HIGH_DEPTH = 13;
   localparam int LOW_DEPTH = 11;

   // ==========================================================
   // queue select codes
   typedef enum logic [1:0] {
      TRS_Q_URGENT = 2'h0,
      TRS_Q_HIGH = 2'h1,
      TRS_Q_LOW = 2'h2
   } trs_queue_type;

   // addressing relation per side
   typedef enum logic [1:0] {
      TRS_AM_FIXED = 2'h0,
      TRS_AM_INC = 2'h1,
      TRS_AM_DEC = 2'h2,
      TRS_AM_INDEX = 2'h3
   } trs_amode_type;

   // memory region classes of a cpu access
   typedef enum logic [2:0] {
      TRS_RG_INTERNAL = 3'h0,
      TRS_RG_CTRL_REG = 3'h1,
      TRS_RG_L2_SRAM = 3'h2,
      TRS_RG_EXT_NC = 3'h3,
      TRS_RG_EXT_C = 3'h4
   } trs_region_type;

   // one transfer request
   typedef struct packed {
      logic [ADDR_W-1:0] src;
      logic [ADDR_W-1:0] dst;
      logic [CNT_W-1:0] count;
      trs_amode_type src_mode;
      trs_amode_type dst_mode;
      trs_queue_type queue;
   } trs_request_type;

   // cpu access from the first-level cache side
   typedef struct packed {
      logic valid;
      logic write;
      trs_region_type region;
      logic l1_hit;
      logic l2_hit;
      logic victim_dirty;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] victim_addr;
   } trs_cpu_type;

   // quick transfer pseudo-register submission
   typedef struct packed {
      logic valid;
      trs_request_type req;
   } trs_quick_type;

   // event channel parameter set at event time
   typedef struct packed {
      logic valid;
      logic src_2d;
      logic dst_2d;
      logic frame_sync_select;
      logic [CNT_W-1:0] elem_count;
      logic [CNT_W-1:0] array_count;
      trs_request_type req;
   } trs_event_type;

   // host data register access
   typedef struct packed {
      logic valid;
      logic write;
      logic auto_inc;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] buf_addr;
   } trs_host_type;

   // count helper used by the event channel path
   function automatic logic [CNT_W-1:0] trs_mul(
      input logic [CNT_W-1:0] a,
      input logic [CNT_W-1:0] b
   );
      logic [2*CNT_W-1:0] p;
      p = a * b;
      return p[CNT_W-1:0];
   endfunction : trs_mul

endpackage : trs_pkg

// ---- trs_slot.sv ----
`timescale 1ns/100ps
// holds one request until the transfer controller takes it
module trs_slot
   import trs_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic load_i,
   input trs_request_type req_i,
   input wire logic accept_i,
   output logic busy_o,
   output trs_request_type req_o
);

   typedef struct packed {
      logic busy;
      trs_request_type req;
   } trs_slot_state_type;

   trs_slot_state_type state;
   trs_slot_state_type next_state;

   // ==========================================================
   // next state
   always_comb begin
      next_state = state;
      if (state.busy && accept_i) begin
         next_state.busy = 1'b0;
      end
      if (load_i && !next_state.busy) begin
         next_state.busy = 1'b1;
         next_state.req = req_i;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign busy_o = state.busy;
   assign req_o = state.req;

endmodule : trs_slot

// ---- trs_submit.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - requests carry addresses, count, modes
// - control register access makes no request
// - second-level sram access makes no request
// - uncached external access: one single element
// - l2 off read miss: 32-byte line
// - l2 miss: two requests, 128 bytes
// - l2 size zero means first level only
// - only dma-bound accesses make requests
// - first-level read hits and l2 hits make no request
// - dirty victim: one writeback request
// - cache urgent, quick high or low
// - one event, exactly one request
// - 1-d: element or frame
// - other: array or whole block
// - host port uses high queue only
// - host fifos of eight words
// - non-increment access: one word
// - increment read, empty fifo: 8 words
// - increment read, half or less: 4
// - every fourth increment write: 4 words
// - urgent 6, high 13, low 11
module trs_submit
   import trs_pkg::*;
#(
   parameter int HOST_DEPTH = FIFO_DEPTH
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input trs_cpu_type cpu_i,
   input wire logic l2_size_zero_i,
   input trs_quick_type quick_i,
   input trs_event_type event_i,
   input trs_host_type host_i,
   input wire logic [3:0] host_rd_level_i,
   input wire logic tc_accept_i,
   output logic cpu_ready_o,
   output logic quick_ready_o,
   output logic event_ready_o,
   output logic host_ready_o,
   output logic cfg_bus_req_o,
   output logic sram_req_o,
   output logic tr_valid_o,
   output trs_request_type tr_o,
   output logic [4:0] urgent_level_o,
   output logic [4:0] high_level_o,
   output logic [4:0] low_level_o
);

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_EVICT = 5'b00010,
      ST_FILL_A = 5'b00100,
      ST_FILL_B = 5'b01000,
      ST_WAIT = 5'b10000
   } trs_cache_state_type;

   typedef struct packed {
      trs_cache_state_type cst;
      trs_cpu_type cpu;
      trs_quick_type quick;
      trs_event_type evt;
      trs_host_type host;
      logic [2:0] wr_since;
      logic cfg_bus_req;
      logic sram_req;
      logic [4:0] urgent_level;
      logic [4:0] high_level;
      logic [4:0] low_level;
   } trs_state_type;

   trs_state_type state;
   trs_state_type next_state;
   trs_request_type pick;
   logic pick_load;
   logic slot_busy;
   trs_request_type slot_req;
   trs_request_type cache_req;
   logic cache_want;
   trs_request_type evt_req;
   trs_request_type host_req;
   logic host_want;

   // build a request from address pair, count, modes and queue
   function automatic trs_request_type make_req(
      input logic [ADDR_W-1:0] s,
      input logic [ADDR_W-1:0] d,
      input logic [CNT_W-1:0] n,
      input trs_amode_type sm,
      input trs_amode_type dm,
      input trs_queue_type q
   );
      trs_request_type r;
      r.src = s;
      r.dst = d;
      r.count = n;
      r.src_mode = sm;
      r.dst_mode = dm;
      r.queue = q;
      return r;
   endfunction : make_req

   // ==========================================================
   // cache requestor request
   always_comb begin
      cache_want = 1'b0;
      cache_req = make_req(state.cpu.addr, state.cpu.addr, ONE_ELEMENT,
         TRS_AM_INC, TRS_AM_INC, TRS_Q_URGENT);
      case (state.cst)
         ST_EVICT: begin
            cache_want = 1'b1;
            cache_req.src = state.cpu.addr;
            cache_req.dst = state.cpu.victim_addr;
            cache_req.count = l2_size_zero_i ? L1_LINE_BYTES :
               L2_LINE_BYTES;
         end
         ST_FILL_A: begin
            cache_want = 1'b1;
            if (state.cpu.region == TRS_RG_EXT_NC ||
                (state.cpu.write && l2_size_zero_i)) begin
               cache_req.count = ONE_ELEMENT;
               cache_req.src_mode = TRS_AM_FIXED;
               cache_req.dst_mode = TRS_AM_FIXED;
            end else if (l2_size_zero_i) begin
               cache_req.count = L1_LINE_BYTES;
            end else begin
               cache_req.count = L2_HALF_BYTES;
            end
         end
         ST_FILL_B: begin
            cache_want = 1'b1;
            cache_req.src = state.cpu.addr + ADDR_W'(L2_HALF_BYTES);
            cache_req.dst = cache_req.src;
            cache_req.count = L2_HALF_BYTES;
         end
         default: begin
            cache_want = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // event channel request size
   always_comb begin
      evt_req = state.evt.req;
      if (!state.evt.src_2d && !state.evt.dst_2d) begin
         evt_req.count = state.evt.frame_sync_select ?
            state.evt.elem_count : ONE_ELEMENT;
      end else begin
         evt_req.count = state.evt.frame_sync_select ?
            trs_mul(state.evt.array_count + ONE_ELEMENT,
               state.evt.elem_count) : state.evt.elem_count;
      end
   end

   // ==========================================================
   // host port request size
   always_comb begin
      host_req = make_req(state.host.addr, state.host.buf_addr,
         ONE_ELEMENT, TRS_AM_INC, TRS_AM_INC, TRS_Q_HIGH);
      host_want = state.host.valid;
      if (state.host.write) begin
         host_req.src = state.host.buf_addr;
         host_req.dst = state.host.addr;
      end
      if (state.host.auto_inc) begin
         if (state.host.write) begin
            host_req.count = HOST_BURST_HALF;
            host_want = state.host.valid &&
               state.wr_since == HOST_WR_GROUP;
         end else if (host_rd_level_i == 4'h0) begin
            host_req.count = 16'(HOST_DEPTH);
         end else if (host_rd_level_i <= HOST_FIFO_HALF) begin
            host_req.count = HOST_BURST_HALF;
         end else begin
            host_want = 1'b0;
         end
      end
   end

   // ==========================================================
   // arbitration into the holding slot, cache first
   always_comb begin
      pick = cache_req;
      pick_load = 1'b0;
      if (!slot_busy) begin
         if (cache_want) begin
            pick_load = 1'b1;
         end else if (state.quick.valid) begin
            pick = state.quick.req;
            if (pick.queue == TRS_Q_URGENT) begin
               pick.queue = TRS_Q_HIGH;
            end
            pick_load = 1'b1;
         end else if (state.evt.valid) begin
            pick = evt_req;
            pick_load = 1'b1;
         end else if (host_want) begin
            pick = host_req;
            pick_load = 1'b1;
         end
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      next_state = state;
      next_state.cfg_bus_req = 1'b0;
      next_state.sram_req = 1'b0;
      // capture cpu access
      if (state.cst == ST_IDLE && cpu_i.valid) begin
         next_state.cpu = cpu_i;
         case (cpu_i.region)
            TRS_RG_CTRL_REG: next_state.cfg_bus_req = 1'b1;
            TRS_RG_L2_SRAM: next_state.sram_req = 1'b1;
            TRS_RG_EXT_NC: next_state.cst = ST_FILL_A;
            TRS_RG_EXT_C: begin
               if (cpu_i.l1_hit && !cpu_i.write) begin
                  next_state.cst = ST_IDLE;
               end else if (!l2_size_zero_i && cpu_i.l2_hit) begin
                  next_state.cst = ST_IDLE;
               end else if (l2_size_zero_i && !cpu_i.write) begin
                  next_state.cst = cpu_i.victim_dirty ? ST_EVICT :
                     ST_FILL_A;
               end else if (l2_size_zero_i) begin
                  next_state.cst = ST_FILL_A;
               end else begin
                  next_state.cst = cpu_i.victim_dirty ? ST_EVICT :
                     ST_FILL_A;
               end
            end
            default: next_state.cst = ST_IDLE;
         endcase
      end else begin
         case (state.cst)
            ST_EVICT: if (pick_load) next_state.cst = ST_FILL_A;
            ST_FILL_A: begin
               if (pick_load) begin
                  next_state.cst = (state.cpu.region == TRS_RG_EXT_C &&
                     !l2_size_zero_i && !state.cpu.write) ?
                     ST_FILL_B : ST_WAIT;
                  if (state.cpu.region == TRS_RG_EXT_C &&
                      !l2_size_zero_i) begin
                     next_state.cst = ST_FILL_B;
                  end
               end
            end
            ST_FILL_B: if (pick_load) next_state.cst = ST_WAIT;
            ST_WAIT: if (!slot_busy) next_state.cst = ST_IDLE;
            default: next_state.cst = ST_IDLE;
         endcase
      end
      if (pick_load && !cache_want && state.quick.valid) begin
         next_state.quick.valid = 1'b0;
      end else if (!state.quick.valid && quick_i.valid) begin
         next_state.quick = quick_i;
      end
      if (pick_load && !cache_want && !state.quick.valid &&
          state.evt.valid) begin
         next_state.evt.valid = 1'b0;
      end else if (!state.evt.valid && event_i.valid) begin
         next_state.evt = event_i;
      end
      // host access retires after its decision
      if (state.host.valid && (pick_load ? (pick == host_req) :
          !host_want)) begin
         next_state.host.valid = 1'b0;
         if (state.host.write && state.host.auto_inc) begin
            next_state.wr_since = (state.wr_since == HOST_WR_GROUP) ?
               3'h0 : state.wr_since;
         end
      end else if (!state.host.valid && host_i.valid) begin
         next_state.host = host_i;
         if (host_i.write && host_i.auto_inc) begin
            next_state.wr_since = state.wr_since + 3'h1;
         end
      end
      if (tc_accept_i && slot_busy) begin
         case (slot_req.queue)
            TRS_Q_URGENT: if (state.urgent_level < 5'(URGENT_DEPTH))
               next_state.urgent_level = state.urgent_level + 5'h1;
            TRS_Q_HIGH: if (state.high_level < 5'(HIGH_DEPTH))
               next_state.high_level = state.high_level + 5'h1;
            default: if (state.low_level < 5'(LOW_DEPTH))
               next_state.low_level = state.low_level + 5'h1;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= trs_state_type'({ST_IDLE,
            {($bits(trs_state_type) - 5){1'b0}}});
      end else begin
         state <= next_state;
      end
   end

   trs_slot u_slot (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(pick_load),
      .req_i(pick),
      .accept_i(tc_accept_i),
      .busy_o(slot_busy),
      .req_o(slot_req)
   );

   // ==========================================================
   // outputs from flip-flops
   assign tr_valid_o = slot_busy;
   assign tr_o = slot_req;
   assign cpu_ready_o = (state.cst == ST_IDLE);
   assign quick_ready_o = !state.quick.valid;
   assign event_ready_o = !state.evt.valid;
   assign host_ready_o = !state.host.valid;
   assign cfg_bus_req_o = state.cfg_bus_req;
   assign sram_req_o = state.sram_req;
   assign urgent_level_o = state.urgent_level;
   assign high_level_o = state.high_level;
   assign low_level_o = state.low_level;

endmodule : trs_submit

// ---- trs_submit_monitor.sv ----
`timescale 1ns/100ps
// ==========================================
// port checker of the request submitter
module trs_submit_monitor
   import trs_pkg::*;
#(
   parameter int HOST_DEPTH = FIFO_DEPTH
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input trs_cpu_type cpu_i,
   input wire logic tc_accept_i,
   input wire logic cpu_ready_o,
   input wire logic cfg_bus_req_o,
   input wire logic sram_req_o,
   input wire logic tr_valid_o,
   input trs_request_type tr_o,
   input wire logic [4:0] urgent_level_o,
   input wire logic [4:0] high_level_o,
   input wire logic [4:0] low_level_o
);
   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // cpu access without a first-level hit taken this cycle
   wire logic take = cpu_i.valid && cpu_ready_o && !cpu_i.l1_hit;
   a_hold_request: assert property (
      tr_valid_o && !tc_accept_i |=> tr_valid_o && $stable(tr_o))
      else $error("request dropped");
   a_queue_legal: assert property (
      tr_valid_o |-> tr_o.queue != 2'h3)
      else $error("bad queue code");
   a_cfg_served: assert property (
      take && cpu_i.region == TRS_RG_CTRL_REG |-> ##[1:2] cfg_bus_req_o)
      else $error("no config bus access");
   a_cfg_pulse: assert property (
      cfg_bus_req_o |=> !cfg_bus_req_o)
      else $error("config pulse too long");
   a_ctrl_no_tr: assert property (
      take && cpu_i.region == TRS_RG_CTRL_REG && !tr_valid_o
      |=> !tr_valid_o [*3])
      else $error("request from register access");
   a_sram_direct: assert property (
      take && cpu_i.region == TRS_RG_L2_SRAM |-> ##[1:2] sram_req_o)
      else $error("sram not served");
   a_ext_answer: assert property (
      take && cpu_i.region == TRS_RG_EXT_NC |-> ##[2:20] tr_valid_o)
      else $error("no external request");
   a_level_cap: assert property (
      urgent_level_o <= 5'h06 && high_level_o <= 5'h0D &&
      low_level_o <= 5'h0B)
      else $error("level over depth");
   a_reset_idle: assert property (
      disable iff (1'b0) sys_rst_i |=> !tr_valid_o && cpu_ready_o &&
      urgent_level_o == 5'h00)
      else $error("reset state wrong");
endmodule : trs_submit_monitor

bind trs_submit trs_submit_monitor #(.HOST_DEPTH(HOST_DEPTH)) mon_u (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_i(cpu_i),
   .tc_accept_i(tc_accept_i), .cpu_ready_o(cpu_ready_o),
   .cfg_bus_req_o(cfg_bus_req_o), .sram_req_o(sram_req_o),
   .tr_valid_o(tr_valid_o), .tr_o(tr_o), .urgent_level_o(urgent_level_o),
   .high_level_o(high_level_o), .low_level_o(low_level_o));

// ---- trs_tc_model.sv ----
`timescale 1ns/100ps
// ==========================================
// transfer controller queue acceptance model
module trs_tc_model (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic slow_i,
   input wire logic valid_i,
   output logic accept_o
);
   logic [1:0] wait_cnt;
   // take the held request at once, or after a three-cycle stall
   // hold until accepted
   always @(negedge clk_i) begin
      if (sys_rst_i || accept_o) begin
         accept_o <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (valid_i) begin
         if (!slow_i || wait_cnt == 2'h3) accept_o <= 1'b1;
         else wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule : trs_tc_model
